// file: hdl/gain3_timer.sv
// gain 3 hold timer in 0.1 ms steps
`timescale 1ns/1ps
module gain3_timer
#(
	parameter int STEP_CYC = servo_tuning_pkg::GAIN3_STEP_CYC // cycles per 0.1 ms
)
(
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, low
	input wire logic start, // begin gain 3 period
	input wire logic [15:0] steps, // effective time in steps
	output logic active // gain 3 in use
);
	logic [15:0] pre_q;
	logic [15:0] cnt_q;
	wire logic tick = (pre_q == 16'(STEP_CYC - 1));

	// prescaler makes the 0.1 ms enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pre_q <= 16'h0000;
		else if (start || tick)
			pre_q <= 16'h0000;
		else
			pre_q <= pre_q + 16'h0001;
	end

	// step count; zero time means gain 3 never engages
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_q <= 16'h0000;
		else if (start)
			cnt_q <= steps;
		else if (tick && cnt_q != 16'h0000)
			cnt_q <= cnt_q - 16'h0001;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			active <= 1'b0;
		else
			active <= (cnt_q != 16'h0000) && !start;
	end

	a_gain3_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(start && steps == 16'h0000) |=> ##1 !active) else $error("gain3 active with zero time");
endmodule // gain3_timer

// file: hdl/servo_special_tuning_objects.sv
// special tuning objects of the servo: registers, offsets, observers, done outputs
`timescale 1ns/1ps
module servo_special_tuning_objects
(
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // response, always okay
	input wire logic cycle_en, // control cycle strobe
	input wire servo_tuning_pkg::loop_in_t loop_in, // loop sample
	input wire logic [31:0] target_pos, // received target position
	output logic signed [15:0] force_out, // force command with offset
	output logic [15:0] gain_out, // active position gain
	output logic [31:0] internal_target, // target used by loop
	output logic speed_obs_en, // speed observer enable
	output logic dist_obs_en, // disturbance observer running
	output logic curr_resp_en, // current response improvement
	output logic position_done_primary, // done output 1
	output logic position_done_secondary, // done output 2
	output logic speed_dev_error // excessive speed deviation
);
	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	logic [15:0] speed_dev_q;
	logic [15:0] gain3_time_q;
	logic [15:0] gain3_ratio_q;
	logic [15:0] force_ofs_q;
	logic [15:0] pos_ofs_q;
	logic [15:0] neg_ofs_q;
	logic [15:0] func_exp_q;
	logic [15:0] pole_method_q;
	servo_tuning_pkg::ahb_addr_t addr_q;
	logic gain3_req_q;
	logic [31:0] last_target_q;
	wire logic gain3_active;

	// clamp a signed value into the offset range
	function automatic logic [15:0] clamp_ofs(input logic [15:0] v);
		if ($signed(v) > $signed(servo_tuning_pkg::MAX_OFS))
			return servo_tuning_pkg::MAX_OFS;
		else if ($signed(v) < $signed(servo_tuning_pkg::MIN_OFS))
			return servo_tuning_pkg::MIN_OFS;
		else
			return v;
	endfunction

	// clamp an unsigned value into [lo, hi]
	function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v > hi)
			return hi;
		else if (v < lo)
			return lo;
		else
			return v;
	endfunction

	// --------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// --------------------------------------------------------------
	wire logic take = hsel && hready && htrans[1];
	wire logic wr_now = addr_q.valid && addr_q.write;
	wire logic [15:0] wd = hwdata[15:0];
	wire logic [15:0] rd_index = haddr[17:2];

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			addr_q <= '0;
		else if (hready)
			addr_q <= '{valid: take, write: hwrite, index: rd_index};
	end

	// write decode; values outside range are clamped to the legal limit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			speed_dev_q <= servo_tuning_pkg::RST_SPEED_DEV;
			gain3_time_q <= servo_tuning_pkg::RST_GAIN3_TIME;
			gain3_ratio_q <= servo_tuning_pkg::RST_GAIN3_RATIO;
			force_ofs_q <= servo_tuning_pkg::RST_OFS;
			pos_ofs_q <= servo_tuning_pkg::RST_OFS;
			neg_ofs_q <= servo_tuning_pkg::RST_OFS;
			func_exp_q <= servo_tuning_pkg::RST_FUNC_EXP;
			pole_method_q <= servo_tuning_pkg::RST_POLE_METHOD;
		end
		else if (wr_now)
		begin
			case (addr_q.index)
				servo_tuning_pkg::IDX_SPEED_DEV:
					speed_dev_q <= clamp_u(wd, 16'h0000, servo_tuning_pkg::MAX_SPEED_DEV);
				servo_tuning_pkg::IDX_GAIN3_TIME:
					gain3_time_q <= clamp_u(wd, 16'h0000, servo_tuning_pkg::MAX_GAIN3_TIME);
				servo_tuning_pkg::IDX_GAIN3_RATIO:
					gain3_ratio_q <= clamp_u(wd, servo_tuning_pkg::MIN_GAIN3_RATIO,
						servo_tuning_pkg::MAX_GAIN3_RATIO);
				servo_tuning_pkg::IDX_FORCE_OFS: force_ofs_q <= clamp_ofs(wd);
				servo_tuning_pkg::IDX_POS_OFS: pos_ofs_q <= clamp_ofs(wd);
				servo_tuning_pkg::IDX_NEG_OFS: neg_ofs_q <= clamp_ofs(wd);
				servo_tuning_pkg::IDX_FUNC_EXP:
					func_exp_q <= wd & servo_tuning_pkg::FUNC_EXP_MASK;
				servo_tuning_pkg::IDX_POLE_METHOD: pole_method_q <= wd;
				default: ;
			endcase
		end
	end

	// status word shows live state of the block
	logic [15:0] status_word;
	always_comb
	begin
		status_word = 16'h0000;
		status_word[servo_tuning_pkg::ST_SPEED_ERR] = speed_dev_error;
		status_word[servo_tuning_pkg::ST_GAIN3] = gain3_active;
		status_word[servo_tuning_pkg::ST_DIST_RUN] = dist_obs_en;
	end
	logic [15:0] rd_mux;
	always_comb
	begin
		case (rd_index)
			servo_tuning_pkg::IDX_SPEED_DEV: rd_mux = speed_dev_q;
			servo_tuning_pkg::IDX_GAIN3_TIME: rd_mux = gain3_time_q;
			servo_tuning_pkg::IDX_GAIN3_RATIO: rd_mux = gain3_ratio_q;
			servo_tuning_pkg::IDX_FORCE_OFS: rd_mux = force_ofs_q;
			servo_tuning_pkg::IDX_POS_OFS: rd_mux = pos_ofs_q;
			servo_tuning_pkg::IDX_NEG_OFS: rd_mux = neg_ofs_q;
			servo_tuning_pkg::IDX_FUNC_EXP: rd_mux = func_exp_q;
			servo_tuning_pkg::IDX_POLE_METHOD: rd_mux = pole_method_q;
			servo_tuning_pkg::IDX_STATUS: rd_mux = status_word;
			default: rd_mux = 16'h0000;
		endcase
	end

	// read data registered in the address phase so it is a flop output
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (take && !hwrite)
			hrdata <= {16'h0000, rd_mux};
	end

	// never stalls, never errors
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// speed deviation and gain switching
	// --------------------------------------------------------------
	speed_dev_check u_dev
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.cycle_en(cycle_en),
		.speed_cmd(loop_in.speed_cmd),
		.speed_meas(loop_in.speed_meas),
		.threshold(speed_dev_q),
		.dev_error(speed_dev_error)
	);

	// rising edge of the gain 3 request starts the hold time
	wire logic gain3_start = loop_in.gain3_request && !gain3_req_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			gain3_req_q <= 1'b0;
		else
			gain3_req_q <= loop_in.gain3_request;
	end

	gain3_timer u_g3
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.start(gain3_start),
		.steps(gain3_time_q),
		.active(gain3_active)
	);

	// gain 3 = gain1 * ratio / 100, saturated to 16 bits
	wire logic [31:0] g3_prod = 32'(loop_in.gain1) * 32'(gain3_ratio_q);
	wire logic [31:0] g3_full = g3_prod / {16'h0000, servo_tuning_pkg::PCT_SCALE};
	wire logic [15:0] gain3 = (g3_full[31:16] != 16'h0000) ? 16'hFFFF : g3_full[15:0];
	wire logic [15:0] gain_d = gain3_active ? gain3 : loop_in.gain1;

	// --------------------------------------------------------------
	// force offsets: percent of rated force added to command
	// --------------------------------------------------------------
	wire logic not_force = loop_in.mode != servo_tuning_pkg::MODE_FORCE;
	wire logic pos_mode = loop_in.mode == servo_tuning_pkg::MODE_POSITION;
	wire logic [15:0] gen_add = not_force ? force_ofs_q : 16'h0000;
	wire logic [15:0] dir_add = !pos_mode ? 16'h0000 :
		loop_in.pos_move ? pos_ofs_q :
		loop_in.neg_move ? neg_ofs_q : 16'h0000;
	// summed at 18 bits and saturated so a large command cannot wrap
	wire logic signed [17:0] force_sum = 18'($signed(loop_in.force_cmd)) +
		18'($signed(gen_add)) + 18'($signed(dir_add));
	wire logic signed [15:0] force_d = (force_sum > 18'sd32767) ? 16'sh7FFF :
		(force_sum < -18'sd32768) ? 16'sh8000 : force_sum[15:0];

	// --------------------------------------------------------------
	// function expansion decode
	// --------------------------------------------------------------
	wire logic dist_d = func_exp_q[servo_tuning_pkg::FX_DIST_OBS] &&
		(!func_exp_q[servo_tuning_pkg::FX_DIST_G1_ONLY] || loop_in.gain1_selected);
	wire logic inp_masked = func_exp_q[servo_tuning_pkg::FX_INP_MASK] &&
		(pole_method_q == servo_tuning_pkg::POLE_METHOD_EST) && !loop_in.pole_done;
	wire logic done1_d = !inp_masked && loop_in.pos_error_small && loop_in.cmd_absent;
	wire logic done2_d = !inp_masked && loop_in.pos_error_small;
	wire logic hold_target = func_exp_q[servo_tuning_pkg::FX_CMD_COMP] && loop_in.comm_error;

	// last good target kept while the link is healthy
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			last_target_q <= 32'h00000000;
		else if (!loop_in.comm_error)
			last_target_q <= target_pos;
	end

	// loop outputs update once per control cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			force_out <= 16'sh0000;
			gain_out <= 16'h0000;
			internal_target <= 32'h00000000;
			position_done_primary <= 1'b0;
			position_done_secondary <= 1'b0;
		end
		else if (cycle_en)
		begin
			force_out <= force_d;
			gain_out <= gain_d;
			internal_target <= hold_target ? last_target_q : target_pos;
			position_done_primary <= done1_d;
			position_done_secondary <= done2_d;
		end
	end

	// observer enables follow the word each clock; dist_obs_en also needs gain1_selected when FX_DIST_G1_ONLY is set
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			speed_obs_en <= 1'b0;
			dist_obs_en <= 1'b0;
			curr_resp_en <= 1'b0;
		end
		else
		begin
			speed_obs_en <= func_exp_q[servo_tuning_pkg::FX_SPEED_OBS];
			dist_obs_en <= dist_d;
			curr_resp_en <= func_exp_q[servo_tuning_pkg::FX_CURR_RESP];
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	sequence s_masked_cycle;
		cycle_en && inp_masked;
	endsequence

	a_mask_done_off: assert property (@(posedge hclk) disable iff (!hresetn)
		s_masked_cycle |=> !position_done_primary && !position_done_secondary)
		else $error("done outputs not masked");
	a_done_plain: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && !func_exp_q[servo_tuning_pkg::FX_INP_MASK]) |=>
		position_done_secondary == $past(loop_in.pos_error_small))
		else $error("done 2 wrong");
	a_done1_plain: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && !func_exp_q[servo_tuning_pkg::FX_INP_MASK]) |=>
		position_done_primary == ($past(loop_in.pos_error_small) && $past(loop_in.cmd_absent)))
		else $error("done 1 wrong");
	a_force_mode_ofs: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && !not_force) |=> force_out == $past(loop_in.force_cmd))
		else $error("offset applied in force mode");
	a_pos_ofs_add: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && pos_mode && loop_in.pos_move && loop_in.force_cmd == 16'sh0000) |=>
		force_out == 16'($signed($past(force_ofs_q)) + $signed($past(pos_ofs_q))))
		else $error("positive offset missing");
	a_neg_ofs_add: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && pos_mode && !loop_in.pos_move && loop_in.neg_move &&
		loop_in.force_cmd == 16'sh0000) |=>
		force_out == 16'($signed($past(force_ofs_q)) + $signed($past(neg_ofs_q))))
		else $error("negative offset missing");
	a_target_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && hold_target) |=> internal_target == $past(last_target_q))
		else $error("target not held");
	a_gain1_plain: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && !gain3_active) |=> gain_out == $past(loop_in.gain1))
		else $error("gain 1 not used outside gain 3 time");
	a_dist_gain1: assert property (@(posedge hclk) disable iff (!hresetn)
		(func_exp_q[servo_tuning_pkg::FX_DIST_G1_ONLY] && !loop_in.gain1_selected) |=> !dist_obs_en)
		else $error("observer ran off gain1");
	a_speed_obs: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> speed_obs_en == $past(func_exp_q[servo_tuning_pkg::FX_SPEED_OBS]))
		else $error("speed observer enable wrong");
	a_curr_resp: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> curr_resp_en == $past(func_exp_q[servo_tuning_pkg::FX_CURR_RESP]))
		else $error("current response enable wrong");
	a_ratio_range: assert property (@(posedge hclk) disable iff (!hresetn)
		gain3_ratio_q >= servo_tuning_pkg::MIN_GAIN3_RATIO &&
		gain3_ratio_q <= servo_tuning_pkg::MAX_GAIN3_RATIO)
		else $error("ratio out of range");
	a_word_mask: assert property (@(posedge hclk) disable iff (!hresetn)
		(func_exp_q & ~servo_tuning_pkg::FUNC_EXP_MASK) == 16'h0000)
		else $error("reserved bits set");
endmodule // servo_special_tuning_objects

// file: hdl/servo_tuning_pkg.sv
// shared constants and types for the servo special tuning block
package servo_tuning_pkg;
	// --------------------------------------------------------------
	// register indices (printed offsets are not word multiples)
	// --------------------------------------------------------------
	localparam logic [15:0] IDX_SPEED_DEV = 16'h3602;
	localparam logic [15:0] IDX_GAIN3_TIME = 16'h3605;
	localparam logic [15:0] IDX_GAIN3_RATIO = 16'h3606;
	localparam logic [15:0] IDX_FORCE_OFS = 16'h3607;
	localparam logic [15:0] IDX_POS_OFS = 16'h3608;
	localparam logic [15:0] IDX_NEG_OFS = 16'h3609;
	localparam logic [15:0] IDX_FUNC_EXP = 16'h3610;
	localparam logic [15:0] IDX_STATUS = 16'h3620;
	localparam logic [15:0] IDX_POLE_METHOD = 16'h3621;
	// --------------------------------------------------------------
	// reset values and limits
	// --------------------------------------------------------------
	localparam logic [15:0] RST_SPEED_DEV = 16'h0000;
	localparam logic [15:0] RST_GAIN3_TIME = 16'h0000;
	localparam logic [15:0] RST_GAIN3_RATIO = 16'h0064;
	localparam logic [15:0] RST_OFS = 16'h0000;
	localparam logic [15:0] RST_FUNC_EXP = 16'h0040;
	localparam logic [15:0] RST_POLE_METHOD = 16'h0000;
	localparam logic [15:0] MAX_SPEED_DEV = 16'h4E20;
	localparam logic [15:0] MAX_GAIN3_TIME = 16'h2710;
	localparam logic [15:0] MIN_GAIN3_RATIO = 16'h0032;
	localparam logic [15:0] MAX_GAIN3_RATIO = 16'h03E8;
	localparam logic [15:0] MAX_OFS = 16'h0064;
	localparam logic [15:0] MIN_OFS = 16'hFF9C;
	localparam logic [15:0] FUNC_EXP_MASK = 16'h00D7;
	localparam logic [15:0] POLE_METHOD_EST = 16'h0002;
	localparam logic [15:0] PCT_SCALE = 16'h0064;
	localparam logic [15:0] ERR_SPEED_DEV = 16'h0241;
	// --------------------------------------------------------------
	// field positions of the function expansion word
	// --------------------------------------------------------------
	localparam int FX_SPEED_OBS = 0;
	localparam int FX_DIST_OBS = 1;
	localparam int FX_DIST_G1_ONLY = 2;
	localparam int FX_CURR_RESP = 4;
	localparam int FX_CMD_COMP = 6;
	localparam int FX_INP_MASK = 7;
	// status word fields
	localparam int ST_SPEED_ERR = 0;
	localparam int ST_GAIN3 = 1;
	localparam int ST_DIST_RUN = 2;
	// --------------------------------------------------------------
	// timing: gain 3 time unit
	// --------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int GAIN3_STEP_NS = 100000;
	localparam int GAIN3_STEP_CYC = GAIN3_STEP_NS * CLK_MHZ / 1000;
	// control modes
	typedef enum logic [1:0] {
		MODE_POSITION = 2'b00,
		MODE_SPEED = 2'b01,
		MODE_FORCE = 2'b10
	} ctrl_mode_t;
	// one control-cycle sample from the loop
	typedef struct packed {
		logic signed [31:0] speed_cmd;
		logic signed [31:0] speed_meas;
		logic signed [15:0] force_cmd;
		logic [15:0] gain1;
		logic [1:0] mode;
		logic pos_move;
		logic neg_move;
		logic pos_error_small;
		logic cmd_absent;
		logic pole_done;
		logic gain3_request;
		logic gain1_selected;
		logic comm_error;
	} loop_in_t;
	// AHB address phase capture
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
	} ahb_addr_t;
endpackage

// file: hdl/speed_dev_check.sv
// speed deviation error detector
`timescale 1ns/1ps
module speed_dev_check
(
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, low
	input wire logic cycle_en, // control cycle strobe
	input wire logic signed [31:0] speed_cmd, // commanded speed mm/s
	input wire logic signed [31:0] speed_meas, // measured speed mm/s
	input wire logic [15:0] threshold, // limit mm/s, 0 = off
	output logic dev_error // sticky error flag
);
	// absolute deviation computed wide to avoid overflow
	wire logic signed [32:0] diff = {speed_cmd[31], speed_cmd} - {speed_meas[31], speed_meas};
	wire logic [32:0] abs_diff = diff[32] ? 33'(-diff) : 33'(diff);
	wire logic over = (threshold != 16'h0000) && (abs_diff > {17'h00000, threshold});

	// error stays until reset; clearing a trip is a drive-level reset action
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dev_error <= 1'b0;
		else if (cycle_en && over)
			dev_error <= 1'b1;
	end

	a_dev_off_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(threshold == 16'h0000 && !dev_error) |=> !dev_error) else $error("trip with zero limit");
	a_dev_trip: assert property (@(posedge hclk) disable iff (!hresetn)
		(cycle_en && over) |=> dev_error) else $error("deviation not flagged");
endmodule // speed_dev_check

// file: testbench/loop_master_model.sv
// model of the network master: control cycle strobe and received target
`timescale 1ns/1ps
module loop_master_model
#(
	parameter int PERIOD = 4 // clocks per control cycle
)
(
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, low
	input wire logic [31:0] good_target, // target the master sends
	input wire logic comm_error, // frame lost on the link
	output logic cycle_en, // one-clock control strobe
	output logic [31:0] target_pos // target as received
);
	int cnt;
	logic [31:0] last_q;
	// free-running control cycle; a lost frame shows the inverse of the last value, so the old target returns every other clock
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= 0;
			last_q <= 32'h00000000;
		end
		else
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			last_q <= target_pos;
		end
	end
	assign cycle_en = (cnt == PERIOD - 1);
	assign target_pos = comm_error ? ~last_q : good_target;
endmodule // loop_master_model

// file: testbench/tb_servo_special_tuning_objects.sv
// self-checking bench for the servo special tuning block
`timescale 1ns/1ps
module tb_servo_special_tuning_objects;
	// ----------------------------------------------------------
	// signals and tables
	// ----------------------------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, target_pos, internal_target, seen, rnd, keep, bus_rd;
	logic hreadyout, hresp, cycle_en, sp_obs, di_obs, cu_resp, done1, done2, dev_err;
	servo_tuning_pkg::loop_in_t loop_in = '0;
	logic [31:0] good_target = 32'h00000000;
	logic signed [15:0] force_out;
	logic [15:0] gain_out;
	logic obs = 1'b0;
	int sel_q[$];
	logic [31:0] exp_q[$];
	int sel;
	int n_errors = 0;
	int n_checks = 0;
	int seed = 32'hb597;
	string names[8] = '{"hrdata", "force_out", "gain_out", "internal_target", "observers",
		"done_outputs", "speed_dev_error", "bus_response"};
	logic [15:0] idx_t[7] = '{servo_tuning_pkg::IDX_SPEED_DEV, servo_tuning_pkg::IDX_GAIN3_TIME,
		servo_tuning_pkg::IDX_GAIN3_RATIO, servo_tuning_pkg::IDX_FORCE_OFS,
		servo_tuning_pkg::IDX_POS_OFS, servo_tuning_pkg::IDX_NEG_OFS, servo_tuning_pkg::IDX_FUNC_EXP};
	logic [15:0] rst_t[7] = '{16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0040};
	logic [15:0] add_t[4] = '{16'h000F, 16'h0003, 16'h000A, 16'h0000};
	logic [1:0] md_t[4] = '{2'b00, 2'b00, 2'b01, 2'b10};
	logic [7:0] fx_t[6] = '{8'h13, 8'h17, 8'h17, 8'hC0, 8'hC0, 8'h40};
	logic [2:0] ex_t[6] = '{3'h7, 3'h5, 3'h7, 3'h0, 3'h3, 3'h2};

	always #2 hclk = ~hclk;

	servo_special_tuning_objects i_dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cycle_en(cycle_en), .loop_in(loop_in),
		.target_pos(target_pos), .force_out(force_out), .gain_out(gain_out),
		.internal_target(internal_target), .speed_obs_en(sp_obs), .dist_obs_en(di_obs),
		.curr_resp_en(cu_resp), .position_done_primary(done1), .position_done_secondary(done2),
		.speed_dev_error(dev_err)
	);
	loop_master_model i_master
	(
		.hclk(hclk), .hresetn(hresetn), .good_target(good_target),
		.comm_error(loop_in.comm_error), .cycle_en(cycle_en), .target_pos(target_pos)
	);
	// ----------------------------------------------------------
	// tasks: bus cycles, notes, comparison, verdict
	// ----------------------------------------------------------
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {14'h0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		// select belongs to the address phase; dropping it here keeps one write per step
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		bus_rd = hrdata;
	endtask
	// a note is paired with one obs pulse; two edges keep obs single-driven per step
	task automatic note(input int s, input logic [31:0] e);
		sel_q.push_back(s);
		exp_q.push_back(e);
		obs <= 1'b1;
		@(posedge hclk);
		obs <= 1'b0;
		@(posedge hclk);
	endtask
	task automatic rd(input logic [15:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h00000000);
		note(0, e);
	endtask
	// two strobes so the second surely saw the new inputs, then one edge to land
	task automatic cyc();
		repeat (2)
		begin
			do @(posedge hclk); while (cycle_en !== 1'b1);
		end
		@(posedge hclk);
	endtask
	task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watcher takes the oldest note when its result is shown
	always @(negedge hclk)
	begin
		if (obs === 1'b1)
		begin
			sel = sel_q.pop_front();
			case (sel)
				0: seen = bus_rd;
				1: seen = {16'h0000, force_out};
				2: seen = {16'h0000, gain_out};
				3: seen = internal_target;
				4: seen = {29'h00000000, cu_resp, di_obs, sp_obs};
				5: seen = {30'h00000000, done2, done1};
				6: seen = {31'h00000000, dev_err};
				default: seen = {30'h00000000, hreadyout, hresp};
			endcase
			check(names[sel], seen, exp_q.pop_front());
		end
	end
	// gain 3 alone holds for 25000 clocks, so the limit covers it with margin
	initial
	begin
		#(4 * 40000);
		n_errors++;
		final_report();
	end
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 7; i++)
			rd(idx_t[i], {16'h0000, rst_t[i]});
		bus(1'b1, servo_tuning_pkg::IDX_FUNC_EXP, 32'h000001FF);
		rd(servo_tuning_pkg::IDX_FUNC_EXP, 32'h000000D7);
		bus(1'b1, 16'h3700, 32'h00001234);
		rd(16'h3700, 32'h00000000);
		note(7, 32'h00000002);
		// speed deviation: off at zero, then exact boundary with meas above cmd
		loop_in.speed_cmd <= 32'sd200;
		loop_in.speed_meas <= 32'sd5200;
		cyc();
		note(6, 32'h00000000);
		bus(1'b1, servo_tuning_pkg::IDX_SPEED_DEV, 32'h00000064);
		loop_in.speed_meas <= 32'sd300;
		cyc();
		note(6, 32'h00000000);
		loop_in.speed_meas <= 32'sd301;
		cyc();
		note(6, 32'h00000001);
		// offsets per mode and direction, random force command
		bus(1'b1, servo_tuning_pkg::IDX_FORCE_OFS, 32'h0000000A);
		bus(1'b1, servo_tuning_pkg::IDX_POS_OFS, 32'h00000005);
		bus(1'b1, servo_tuning_pkg::IDX_NEG_OFS, 32'h0000FFF9);
		for (int k = 0; k < 4; k++)
		begin
			rnd = $random(seed);
			// zero command on the position steps lets the offset assertions fire
			loop_in.force_cmd <= {11'h000, (k < 2) ? 5'h00 : rnd[4:0]};
			loop_in.mode <= md_t[k];
			loop_in.pos_move <= (k != 1);
			loop_in.neg_move <= (k == 1);
			cyc();
			note(1, {27'h0000000, (k < 2) ? 5'h00 : rnd[4:0]} + {16'h0000, add_t[k]});
		end
		// observer bits, then done outputs with pole estimation masking
		bus(1'b1, servo_tuning_pkg::IDX_POLE_METHOD, 32'h00000002);
		loop_in.pos_error_small <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			bus(1'b1, servo_tuning_pkg::IDX_FUNC_EXP, {24'h000000, fx_t[k]});
			loop_in.gain1_selected <= (k == 2);
			loop_in.pole_done <= (k == 4);
			loop_in.cmd_absent <= (k != 5);
			cyc();
			note(k < 3 ? 4 : 5, {29'h00000000, ex_t[k]});
		end
		// command compensation after a lost frame
		keep = $random(seed);
		good_target <= keep;
		cyc();
		note(3, keep);
		loop_in.comm_error <= 1'b1;
		good_target <= ~keep;
		cyc();
		note(3, keep);
		// gain 3 hold of one step at ratio 200 percent
		bus(1'b1, servo_tuning_pkg::IDX_GAIN3_RATIO, 32'h000000C8);
		bus(1'b1, servo_tuning_pkg::IDX_GAIN3_TIME, 32'h00000001);
		loop_in.gain1 <= 16'h0032;
		loop_in.gain3_request <= 1'b1;
		repeat (4) @(posedge hclk);
		cyc();
		note(2, 32'h00000064);
		rd(servo_tuning_pkg::IDX_STATUS, 32'h00000003);
		repeat (25020) @(posedge hclk);
		cyc();
		note(2, 32'h00000032);
		final_report();
	end
endmodule // tb_servo_special_tuning_objects
